// ### core/serial_config_pkg.sv
// constants and types shared by the serial configuration ports
package serial_config_pkg;

    // core clock and two-wire bit timing
    localparam int CLK_NS      = 50;
    localparam int I2C_BPS     = 50000;
    localparam int I2C_BIT_NS  = 1000000000 / I2C_BPS;
    localparam int I2C_QTR_CYC = I2C_BIT_NS / (4 * CLK_NS);

    // EEPROM addressing; device code value is arbitrary
    localparam logic [6:0] EE_DEV  = 7'h50;
    localparam logic [7:0] EE_WORD = 8'h00;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // serial frame layout
    localparam int ID_W      = 3;
    localparam int REG_W     = 3;
    localparam int WD_W      = 16;
    localparam int WEND_BITS = 2;
    localparam int RD_TURN   = 4;
    localparam int DEB_CYC   = 8;

    // indirect access locations and index flags
    localparam logic [REG_W-1:0] LOC_INDEX = 3'h0;
    localparam logic [REG_W-1:0] LOC_DATA  = 3'h2;
    localparam int               IDX_INC   = 15;
    localparam int               IDX_PAIR  = 14;
    localparam logic [15:0]      IDX_RST   = 16'h0000;

    typedef enum logic [1:0] {
        I_START = 2'b00,
        I_BIT   = 2'b01,
        I_STOP  = 2'b10,
        I_DONE  = 2'b11
    } i2c_state_type;

    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_ADDR  = 3'b001,
        L_CMD   = 3'b010,
        L_WDATA = 3'b011,
        L_WEND  = 3'b100,
        L_TURN  = 3'b101,
        L_RDATA = 3'b110
    } link_state_type;

endpackage : serial_config_pkg

// ### core/serial_config_ports.sv
// boot EEPROM loader and synchronous serial slave port with config bank
`timescale 1ns/100ps
module serial_config_ports
    import serial_config_pkg::*;
#(
    parameter int CFG_DEPTH = 64,
    parameter int QTR_CYC   = I2C_QTR_CYC,
    parameter int DEB_LEN   = DEB_CYC,
    parameter int TURN_LEN  = RD_TURN
) (
    // core clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // sync serial port
    input  wire logic                   SHIFT_CLK,
    input  wire logic                   SERIAL_IN_LINE,
    output logic                        SERIAL_OUT_LINE,
    output logic                        SERIAL_OUT_LINE_OE,
    input  wire logic                   DEBOUNCE_EN,
    input  wire logic [ID_W-1:0]        ID_STRAP,
    // two-wire EEPROM bus
    output logic                        SCL_O,
    output logic                        SCL_OE,
    input  wire logic                   SDA_I,
    output logic                        SDA_O,
    output logic                        SDA_OE,
    // boot status and configuration bank
    output logic                        LOAD_DONE,
    output logic                        LOAD_ERR,
    output logic [8*CFG_DEPTH-1:0]      CFG_BYTES
);

    localparam int AW = $clog2(CFG_DEPTH);
    localparam int AB = ID_W + REG_W;

    typedef struct packed {
        i2c_state_type                i_st;
        logic [15:0]                  qc;
        logic [1:0]                   ph;
        logic [3:0]                   bc;
        logic [1:0]                   step;
        logic [7:0]                   sh;
        logic [15:0]                  n;
        logic                         scl_oe;
        logic                         sda_oe;
        logic                         lvl;
        logic                         sda_s1;
        logic                         sda_s2;
        logic                         load_done;
        logic                         load_err;
        logic [ID_W-1:0]              id_s1;
        logic [ID_W-1:0]              id_s2;
        logic [ID_W-1:0]              id_q;
        logic                         deb_s1;
        logic                         deb_s2;
        logic                         wr_s1;
        logic                         wr_s2;
        logic                         wr_seen;
        logic                         rd_s1;
        logic                         rd_s2;
        logic                         rd_seen;
        logic                         dn_s1;
        logic                         dn_s2;
        logic                         dn_seen;
        logic [7:0]                   dcnt;
        logic [15:0]                  idx;
        logic [15:0]                  rdw;
        logic                         ack_tg;
        logic                         drive;
        logic [CFG_DEPTH-1:0][7:0]    cfg;
    } core_type;

    typedef struct packed {
        logic                         rs1;
        logic                         rs2;
        link_state_type               st;
        logic [4:0]                   cnt;
        logic [15:0]                  sh;
        logic [AB-1:0]                addr;
        logic [15:0]                  wdata;
        logic                         wr_tg;
        logic                         rd_tg;
        logic                         dn_tg;
        logic                         ak_s1;
        logic                         ak_s2;
        logic [15:0]                  rdsh;
        logic                         dout;
    } link_type;

    core_type c_q;
    core_type c_d;
    link_type l_q;
    link_type l_d;
    logic     rise_q;

    // bank index from a 16-bit configuration address, wraps at the bank size
    function automatic logic [AW-1:0] cidx(input logic [15:0] a);
        return a[AW-1:0];
    endfunction : cidx

    // core domain: EEPROM loader and serial request handling
    always_comb begin
        logic tick;
        logic last;
        logic pend_w;
        logic pend_r;
        logic go;
        logic sel;
        logic [REG_W-1:0] loc;
        // quarter-bit tick sets the bus rate
        tick   = (c_q.qc == 16'(QTR_CYC - 1));
        last   = (c_q.n == 16'(CFG_DEPTH - 1));
        c_d    = c_q;
        c_d.qc = tick ? 16'h0000 : c_q.qc + 16'h0001;

        // pin inputs pass two flops before use
        c_d.sda_s1 = SDA_I;
        c_d.sda_s2 = c_q.sda_s1;
        c_d.id_s1  = ID_STRAP;
        c_d.id_s2  = c_q.id_s1;
        c_d.deb_s1 = DEBOUNCE_EN;
        c_d.deb_s2 = c_q.deb_s1;
        c_d.wr_s1  = l_q.wr_tg;
        c_d.wr_s2  = c_q.wr_s1;
        c_d.rd_s1  = l_q.rd_tg;
        c_d.rd_s2  = c_q.rd_s1;
        c_d.dn_s1  = l_q.dn_tg;
        c_d.dn_s2  = c_q.dn_s1;

        if (tick && c_q.i_st != I_DONE) begin
            c_d.ph = c_q.ph + 2'b01;
        end
        unique case (c_q.i_st)
            I_START: begin
                if (tick && c_q.ph == 2'b11) begin
                    c_d.i_st = I_BIT;
                    c_d.bc   = 4'h0;
                end
            end
            I_BIT: begin
                if (tick && c_q.ph == 2'b11) begin
                    if (c_q.bc != ACK_BIT) begin
                        c_d.sh = (c_q.step == 2'b11) ? {c_q.sh[6:0], c_q.sda_s2}
                                                     : {c_q.sh[6:0], 1'b0};
                        c_d.bc = c_q.bc + 4'h1;
                    end else if (c_q.step != 2'b11 && c_q.sda_s2) begin
                        c_d.load_err = 1'b1;
                        c_d.i_st     = I_STOP;
                    end else begin
                        c_d.bc = 4'h0;
                        unique case (c_q.step)
                            2'b00: begin
                                c_d.step = 2'b01;
                                c_d.sh   = EE_WORD;
                            end
                            2'b01: begin
                                c_d.step = 2'b10;
                                c_d.sh   = {EE_DEV, 1'b1};
                                c_d.i_st = I_START;
                            end
                            2'b10: begin
                                c_d.step = 2'b11;
                            end
                            2'b11: begin
                                c_d.cfg[cidx(c_q.n)] = c_q.sh;
                                c_d.n                = c_q.n + 16'h0001;
                                if (last) begin
                                    c_d.i_st = I_STOP;
                                end
                            end
                        endcase
                    end
                end
            end
            I_STOP: begin
                // stop ends the load, bus free
                if (tick && c_q.ph == 2'b11) begin
                    c_d.i_st      = I_DONE;
                    c_d.load_done = 1'b1;
                end
            end
            I_DONE: begin
                c_d.ph = 2'b00;
            end
        endcase

        // line levels; data only moves in the second low quarter
        unique case (c_d.i_st)
            I_START: begin
                c_d.scl_oe = (c_d.ph == 2'b00) || (c_d.ph == 2'b11);
                c_d.sda_oe = c_d.ph[1];
            end
            I_BIT: begin
                // clock high in quarters two and three
                c_d.scl_oe = ~c_d.ph[1];
                if (c_d.ph == 2'b00) begin
                    c_d.sda_oe = c_q.sda_oe;
                end else if (c_d.bc != ACK_BIT) begin
                    c_d.sda_oe = (c_d.step != 2'b11) && !c_d.sh[7];
                end else begin
                    // ack our reads, release for the last one
                    c_d.sda_oe = (c_d.step == 2'b11) && (c_d.n != 16'(CFG_DEPTH - 1));
                end
            end
            I_STOP: begin
                c_d.scl_oe = ~c_d.ph[1];
                c_d.sda_oe = (c_d.ph == 2'b00) ? c_q.sda_oe : (c_d.ph != 2'b11);
            end
            I_DONE: begin
                c_d.scl_oe = 1'b0;
                c_d.sda_oe = 1'b0;
            end
        endcase

        // serial requests wait until the load is over
        pend_w = (c_q.wr_s2 != c_q.wr_seen);
        pend_r = (c_q.rd_s2 != c_q.rd_seen);
        // hold-off count, skipped when debounce is off
        if ((pend_w || pend_r) && c_q.load_done) begin
            c_d.dcnt = (c_q.dcnt == 8'(DEB_LEN)) ? c_q.dcnt : c_q.dcnt + 8'h01;
        end else begin
            c_d.dcnt = 8'h00;
        end
        go  = c_q.load_done && (!c_q.deb_s2 || c_q.dcnt == 8'(DEB_LEN));
        sel = (l_q.addr[AB-1:REG_W] == c_q.id_q);
        loc = l_q.addr[REG_W-1:0];

        if (go && pend_w) begin
            c_d.wr_seen = c_q.wr_s2;
            c_d.dcnt    = 8'h00;
            if (sel && loc == LOC_INDEX) begin
                c_d.idx = l_q.wdata;
            end else if (sel && loc == LOC_DATA) begin
                c_d.cfg[cidx(c_q.idx)] = l_q.wdata[7:0];
                if (c_q.idx[IDX_PAIR]) begin
                    c_d.cfg[cidx(c_q.idx + 16'h0001)] = l_q.wdata[15:8];
                end
                if (c_q.idx[IDX_INC]) begin
                    c_d.idx = c_q.idx + (c_q.idx[IDX_PAIR] ? 16'h0002 : 16'h0001);
                end
            end
        end else if (go && pend_r) begin
            c_d.rd_seen = c_q.rd_s2;
            c_d.dcnt    = 8'h00;
            c_d.drive   = sel;
            c_d.ack_tg  = ~c_q.ack_tg;
            c_d.rdw     = 16'h0000;
            if (loc == LOC_INDEX) begin
                c_d.rdw = c_q.idx;
            end else if (loc == LOC_DATA) begin
                c_d.rdw = {8'h00, c_q.cfg[cidx(c_q.idx)]};
                if (sel && c_q.idx[IDX_INC]) begin
                    c_d.idx = c_q.idx + 16'h0001;
                end
            end
        end

        // read shift finished, let go of the shared output line
        if (c_q.dn_s2 != c_q.dn_seen) begin
            c_d.dn_seen = c_q.dn_s2;
            c_d.drive   = 1'b0;
        end
    end

    // core register; strap taken from its synchroniser while in reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            c_q        <= '0;
            c_q.i_st   <= I_START;
            c_q.sh     <= {EE_DEV, 1'b0};
            c_q.idx    <= IDX_RST;
            c_q.id_s1  <= c_d.id_s1;
            c_q.id_s2  <= c_d.id_s2;
            c_q.id_q   <= c_q.id_s2;
        end else begin
            c_q <= c_d;
        end
    end

    // first half of each shift pulse: sample at rising edge
    always_ff @(posedge SHIFT_CLK) begin
        rise_q <= SERIAL_IN_LINE;
    end

    // link domain: frame decode on falling shift edge
    always_comb begin
        logic start;
        logic abort;
        logic in_rd;
        l_d       = l_q;
        l_d.rs1   = RST;
        l_d.rs2   = l_q.rs1;
        l_d.ak_s1 = c_q.ack_tg;
        l_d.ak_s2 = l_q.ak_s1;
        start     = rise_q && !SERIAL_IN_LINE;
        abort     = !rise_q && SERIAL_IN_LINE;
        in_rd     = (l_q.st == L_TURN) || (l_q.st == L_RDATA);
        if (l_q.rs2) begin
            l_d.st    = L_IDLE;
            l_d.cnt   = 5'h00;
            l_d.wr_tg = 1'b0;
            l_d.rd_tg = 1'b0;
            l_d.dn_tg = 1'b0;
            l_d.dout  = 1'b0;
        end else if (start && !in_rd) begin
            l_d.st  = L_ADDR;
            l_d.cnt = 5'h00;
            l_d.sh  = 16'h0000;
        end else if (abort && !in_rd) begin
            // abort before the read command or in a write
            l_d.st = L_IDLE;
        end else begin
            unique case (l_q.st)
                L_IDLE: begin
                    l_d.cnt = 5'h00;
                end
                L_ADDR: begin
                    l_d.sh  = {l_q.sh[14:0], SERIAL_IN_LINE};
                    l_d.cnt = l_q.cnt + 5'h01;
                    if (l_q.cnt == 5'(AB - 1)) begin
                        l_d.addr = {l_q.sh[AB-2:0], SERIAL_IN_LINE};
                        l_d.st   = L_CMD;
                        l_d.cnt  = 5'h00;
                    end
                end
                L_CMD: begin
                    // high is read, low is write, no ack slot
                    if (SERIAL_IN_LINE) begin
                        l_d.st    = L_TURN;
                        l_d.rd_tg = ~l_q.rd_tg;
                    end else begin
                        l_d.st = L_WDATA;
                    end
                end
                L_WDATA: begin
                    l_d.sh  = {l_q.sh[14:0], SERIAL_IN_LINE};
                    l_d.cnt = l_q.cnt + 5'h01;
                    if (l_q.cnt == 5'(WD_W - 1)) begin
                        l_d.wdata = {l_q.sh[14:0], SERIAL_IN_LINE};
                        l_d.st    = L_WEND;
                        l_d.cnt   = 5'h00;
                    end
                end
                L_WEND: begin
                    // two high pulses commit the write
                    l_d.cnt = l_q.cnt + 5'h01;
                    if (!SERIAL_IN_LINE) begin
                        l_d.st = L_IDLE;
                    end else if (l_q.cnt == 5'(WEND_BITS - 1)) begin
                        l_d.wr_tg = ~l_q.wr_tg;
                        l_d.st    = L_IDLE;
                    end
                end
                L_TURN: begin
                    // turnaround, also waits for the core's answer
                    if (l_q.cnt != 5'(TURN_LEN - 1)) begin
                        l_d.cnt = l_q.cnt + 5'h01;
                    end else if (l_q.ak_s2 == l_q.rd_tg) begin
                        l_d.rdsh = c_q.rdw;
                        l_d.st   = L_RDATA;
                        l_d.cnt  = 5'h00;
                    end
                end
                L_RDATA: begin
                    l_d.dout = l_q.rdsh[15];
                    l_d.rdsh = {l_q.rdsh[14:0], 1'b0};
                    l_d.cnt  = l_q.cnt + 5'h01;
                    if (l_q.cnt == 5'(WD_W - 1)) begin
                        l_d.dn_tg = ~l_q.dn_tg;
                        l_d.st    = L_IDLE;
                    end
                end
                default: begin
                    l_d.st = L_IDLE;
                end
            endcase
        end
    end

    // link register; the shift clock may stop between frames
    always_ff @(negedge SHIFT_CLK) begin
        l_q <= l_d;
    end

    // outputs straight from flops; two-wire bus pins only ever pull low
    assign SCL_O              = c_q.lvl;
    assign SCL_OE             = c_q.scl_oe;
    assign SDA_O              = c_q.lvl;
    assign SDA_OE             = c_q.sda_oe;
    assign LOAD_DONE          = c_q.load_done;
    assign LOAD_ERR           = c_q.load_err;
    assign CFG_BYTES          = c_q.cfg;
    assign SERIAL_OUT_LINE    = l_q.dout;
    assign SERIAL_OUT_LINE_OE = c_q.drive;

endmodule : serial_config_ports

// ### test/eeprom_model.sv
// two-wire EEPROM partner for the boot loader
`timescale 1ns/100ps
module eeprom_model #(
    parameter int                 DEPTH = 4,
    parameter logic [8*DEPTH-1:0] IMG   = '0
) (
    // wire levels
    input wire logic    scl,
    input wire logic    sda,
    // fault control and observation
    input wire logic    nack_all,
    output logic        sda_oe,
    output logic [23:0] hdr
);
    logic [7:0] sh, cur;
    logic       tx, rd, first, mack;
    int         n, ptr;
    initial sda_oe = 1'b0;
    // start or stop seen: let go of the line, restart framing
    always @(sda) if (scl === 1'b1) begin
        n = 0;
        tx = 1'b0;
        rd = 1'b0;
        first = !sda;
        sda_oe = 1'b0;
    end
    // bits in MSB first, master ack kept for the ninth pulse
    always @(posedge scl) begin
        n = n + 1;
        if (!tx && n <= 8) sh = {sh[6:0], sda};
        mack = !sda;
    end
    // the line only moves while the clock is low
    always @(negedge scl) begin
        if (n == 8) begin
            // receiver pulls ack low, transmitter lets go
            sda_oe = !tx && !nack_all;
            if (!tx) hdr = {hdr[15:0], sh};
            if (!tx && first) rd = sh[0];
            if (!tx && !first) ptr = sh;
            first = 1'b0;
        end else if (n == 9) begin
            n = 0;
            // stop sending once the master withholds its ack
            tx = rd && (mack || !tx);
            cur = IMG[8*(ptr%DEPTH)+:8];
            if (tx) ptr = ptr + 1;
            sda_oe = tx && !cur[7];
        end else if (tx) begin
            sda_oe = !cur[7-n];
        end
    end
endmodule : eeprom_model

// ### test/serial_config_monitor.sv
// checker for boot bus timing and status
`timescale 1ns/100ps
module serial_config_monitor
    import serial_config_pkg::*;
#(
    parameter int CFG_DEPTH = 64,
    parameter int QTR_CYC   = I2C_QTR_CYC
) (
    // clock and reset
    input wire logic                   CLK,
    input wire logic                   RST,
    // bus and status
    input wire logic                   SCL_O,
    input wire logic                   SCL_OE,
    input wire logic                   SDA_O,
    input wire logic                   SDA_OE,
    input wire logic                   SERIAL_OUT_LINE_OE,
    input wire logic                   LOAD_DONE,
    input wire logic                   LOAD_ERR,
    input wire logic [8*CFG_DEPTH-1:0] CFG_BYTES
);
    localparam int QW  = QTR_CYC + 1;
    localparam int QW2 = 2 * QTR_CYC + 3;
    localparam int QW4 = 4 * QTR_CYC + 1;
    int   hi_q;
    logic seen_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // released-clock length; the first release after reset is no bit
    always_ff @(posedge CLK) begin
        hi_q   <= (RST || SCL_OE) ? 0 : hi_q + 1;
        seen_q <= !RST && (seen_q || SCL_OE);
    end
    a_pull_only: assert property (!SCL_O && !SDA_O)
        else $error("bus line driven high");
    a_clock_high: assert property ($rose(SCL_OE) && seen_q |-> hi_q == 2 * QTR_CYC)
        else $error("clock high time wrong");
    a_start_shape: assert property ($rose(SDA_OE) && !SCL_OE |-> ##[1:QW] SCL_OE)
        else $error("start not followed by clock low");
    a_data_hold: assert property ($fell(SCL_OE) |-> $stable(SDA_OE) [*2])
        else $error("data moved at clock release");
    a_idle_free: assert property (LOAD_DONE |-> !SCL_OE && !SDA_OE)
        else $error("bus held after load");
    a_err_clean: assert property ($rose(LOAD_ERR) |-> CFG_BYTES == '0 ##[0:QW4] LOAD_DONE)
        else $error("refused load not ended cleanly");
    a_stop_done: assert property ($fell(SDA_OE) && !SCL_OE |-> ##[1:QW2] LOAD_DONE)
        else $error("stop without load end");
    a_boot_first: assert property (SERIAL_OUT_LINE_OE |-> LOAD_DONE)
        else $error("serial answer before load");
endmodule : serial_config_monitor

// ### test/tb.sv
// bench: boot load, serial access and faults, refused load
`timescale 1ns/100ps
module tb
    import serial_config_pkg::*;
;
    localparam int          DEPTH = 4;
    localparam int          TURN  = 4;
    localparam logic [31:0] IMG   = 32'h5AC3_0FF0;
    localparam logic [2:0]  ME    = 3'h5;
    logic        clk, rst, sclk, sin, deb, nack, so, oe, so_s, oe_s;
    logic        scl_oe, sda_oe, ee_oe, sda_w, done, err, seen;
    logic [31:0] bank;
    logic [23:0] hdr;
    logic [15:0] q;
    int          fail_count, samples_checked, cycles;
    // open-drain wire with pull-up
    assign sda_w = !(sda_oe || ee_oe);
    serial_config_ports #(.CFG_DEPTH(DEPTH), .QTR_CYC(2), .TURN_LEN(TURN)) dut_u (
        .CLK(clk), .RST(rst), .SHIFT_CLK(sclk), .SERIAL_IN_LINE(sin),
        .SERIAL_OUT_LINE(so), .SERIAL_OUT_LINE_OE(oe), .DEBOUNCE_EN(deb), .ID_STRAP(ME),
        .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe),
        .LOAD_DONE(done), .LOAD_ERR(err), .CFG_BYTES(bank));
    eeprom_model #(.DEPTH(DEPTH), .IMG(IMG)) ee_u (
        .scl(!scl_oe), .sda(sda_w), .nack_all(nack), .sda_oe(ee_oe), .hdr(hdr));
    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end
    // hang guard far beyond the 1400 or so cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // one 80 ns shift pulse: a at the rise, b at the fall, output taken after
    task automatic pulse(input logic a, input logic b);
        sin = a;
        #20 sclk = 1'b1;
        #20 sin = b;
        #20 sclk = 1'b0;
        #20 so_s = so;
        oe_s = oe;
    endtask : pulse
    task automatic send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) pulse(v[i], v[i]);
    endtask : send
    task automatic cmd(input logic [2:0] id, input logic [2:0] loc, input logic rd);
        @(posedge clk);
        #1 pulse(1'b1, 1'b0);
        send({9'h000, id, loc, rd}, 7);
    endtask : cmd
    // idle line shows the inverse; room for the core to act
    task automatic gap();
        sin = !sin;
        repeat (20) @(posedge clk);
    endtask : gap
    task automatic ser_wr(input logic [2:0] id, input logic [2:0] loc, input logic [15:0] d);
        cmd(id, loc, 1'b0);
        send(d, 16);
        send(16'h0003, 2);
        gap();
    endtask : ser_wr
    // clock stands still before turnaround so the core has answered
    task automatic ser_rd(input logic [2:0] id, input logic [2:0] loc);
        seen = 1'b0;
        cmd(id, loc, 1'b1);
        repeat (30) @(posedge clk);
        send(16'h0000, TURN);
        for (int i = 0; i < 16; i++) begin
            pulse(1'b0, 1'b0);
            q = {q[14:0], so_s};
            seen = seen | oe_s;
        end
        gap();
    endtask : ser_rd
    // link reset is two flops deep: two pulses inside reset, two after
    task automatic boot(input logic refuse);
        @(posedge clk);
        #1 rst = 1'b1;
        nack = refuse;
        pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b0);
        for (int n = 0; n < 3000 && done !== 1'b1; n++) @(posedge clk);
        #1 chk(done, 1, "load end");
    endtask : boot
    task automatic t_boot_ok();
        boot(1'b0);
        chk(err, 0, "load error");
        chk(bank, IMG, "bank image");
        chk(hdr, {EE_DEV, 1'b0, EE_WORD, EE_DEV, 1'b1}, "header bytes");
        chk({scl_oe, sda_oe}, 0, "idle lines");
        $display("test boot_ok done");
    endtask : t_boot_ok
    task automatic t_serial();
        ser_wr(ME, LOC_INDEX, 16'h4001);
        ser_wr(ME, LOC_DATA, 16'h7E81);
        chk(bank, 32'h5A7E_81F0, "paired write");
        ser_rd(ME, LOC_INDEX);
        chk({seen, q}, 32'h0001_4001, "index read");
        ser_rd(ME, LOC_DATA);
        chk(q, 16'h0081, "data read");
        ser_wr(3'h2, LOC_DATA, 16'h1234);
        ser_rd(3'h2, LOC_INDEX);
        chk(seen, 0, "foreign read driven");
        cmd(ME, LOC_DATA, 1'b0);
        send(16'h00FF, 8);
        pulse(1'b0, 1'b1);
        gap();
        chk(bank, 32'h5A7E_81F0, "dropped writes");
        deb = 1'b0;
        ser_wr(ME, LOC_INDEX, 16'h8003);
        ser_wr(ME, LOC_DATA, 16'h0011);
        chk(bank, 32'h117E_81F0, "fast write");
        ser_rd(ME, LOC_INDEX);
        chk(q, 16'h8004, "index step");
        $display("test serial done");
    endtask : t_serial
    task automatic t_boot_nack();
        boot(1'b1);
        chk(err, 1, "refused load flag");
        chk(bank, 0, "refused load bank");
        chk({scl_oe, sda_oe}, 0, "bus freed");
        $display("test boot_nack done");
    endtask : t_boot_nack
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {rst, sclk, sin, nack, deb} = 5'h11;
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        t_boot_ok();
        t_serial();
        t_boot_nack();
        report_and_stop();
    end
endmodule : tb
bind serial_config_ports serial_config_monitor #(.CFG_DEPTH(CFG_DEPTH), .QTR_CYC(QTR_CYC)) mon_u (
    .CLK(CLK), .RST(RST), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
    .SERIAL_OUT_LINE_OE(SERIAL_OUT_LINE_OE), .LOAD_DONE(LOAD_DONE), .LOAD_ERR(LOAD_ERR),
    .CFG_BYTES(CFG_BYTES));
